// ==== src/sdw_consts.vh ====
/*
 * Constants for the serial write front end: word size, FIFO shape,
 * timing figures and the system clock rate.
 * Assumes inclusion by bare name from the design files only.
 */
`ifndef SDW_CONSTS_VH
`define SDW_CONSTS_VH

`define SDW_WORD_BITS 24
`define SDW_CNT_BITS 5
`define SDW_FIFO_DEPTH 32
`define SDW_CLK_SYS_MHZ 100
`define SDW_SCLK_MAX_MHZ 50
`define SDW_SYS_PERIOD_NS 10
`define SDW_SYNC_STAGES 3

`endif

// ==== src/sdw_fifo.v ====
/*
 * Synchronous FIFO with valid/ready on both sides.
 * Assumes a single clock and an active-low asynchronous reset.
 */
`timescale 1ns/1ps

module sdw_fifo #(
  parameter WIDTH = 24,
  parameter DEPTH = 32,
  parameter AW = 5
) (
  input wire clk_sys_in,
  input wire rst_n_in,
  input wire [WIDTH-1:0] wr_data_in,
  input wire wr_valid_in,
  output wire wr_ready_out,
  output wire [WIDTH-1:0] rd_data_out,
  output wire rd_valid_out,
  input wire rd_ready_in
);

  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr;
  reg [AW-1:0] rd_ptr;
  reg [AW:0] count;
  wire do_wr;
  wire do_rd;

  assign wr_ready_out = (count != DEPTH[AW:0]);
  assign rd_valid_out = (count != {(AW+1){1'b0}});
  assign rd_data_out = mem[rd_ptr];
  assign do_wr = wr_valid_in && wr_ready_out;
  assign do_rd = rd_valid_out && rd_ready_in;

  always @(posedge clk_sys_in)
  begin
    if (do_wr)
      mem[wr_ptr] <= wr_data_in;
  end

  always @(posedge clk_sys_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
    end
    else
    begin
      if (do_wr)
        wr_ptr <= wr_ptr + {{(AW-1){1'b0}}, 1'b1};
      if (do_rd)
        rd_ptr <= rd_ptr + {{(AW-1){1'b0}}, 1'b1};
      if (do_wr && !do_rd)
        count <= count + {{AW{1'b0}}, 1'b1};
      else if (do_rd && !do_wr)
        count <= count - {{AW{1'b0}}, 1'b1};
    end
  end

endmodule // sdw_fifo

// ==== src/sdw_frontend.v ====
/*
 * Serial write front end: samples frame select, serial clock and data
 * pins on the system clock, shifts 24-bit words and queues them.
 * Assumes serial clock well below half the system clock rate.
 */
`timescale 1ns/1ps
`include "sdw_consts.vh"

module sdw_frontend #(
  parameter WORD_BITS = `SDW_WORD_BITS,
  parameter FIFO_DEPTH = `SDW_FIFO_DEPTH
) (
  input wire clk_sys_in,
  input wire rst_n_in,
  input wire sync_n_in,
  input wire sclk_in,
  input wire din_in,
  output reg active_out,
  output reg [WORD_BITS-1:0] word_out,
  output reg word_valid_out,
  input wire word_ready_in,
  output reg update_out,
  output reg abort_out,
  output reg overflow_out
);

  // Bits to index n items (0 to n-1); sizes the bit counter and the FIFO pointers
  function integer bits_for;
    input integer n;
    integer v;
    begin
      v = n - 1;
      bits_for = 0;
      while (v > 0)
      begin
        bits_for = bits_for + 1;
        v = v >> 1;
      end
      if (bits_for < 1)
        bits_for = 1;
    end
  endfunction

  localparam CW = bits_for(WORD_BITS);
  localparam AW = bits_for(FIFO_DEPTH);
  localparam [2:0] ST_IDLE = 3'h1;
  localparam [2:0] ST_SHIFT = 3'h2;
  localparam [2:0] ST_DONE = 3'h4;

  reg [2:0] sync_pipe;
  reg [2:0] sclk_pipe;
  reg [2:0] din_pipe;
  reg sync_q;
  reg sclk_q;
  reg [2:0] state;
  reg [2:0] next_state;
  reg [WORD_BITS-1:0] shreg;
  reg [CW-1:0] bit_cnt;
  reg push;
  reg [WORD_BITS-1:0] push_data;
  wire fifo_ready;
  wire [WORD_BITS-1:0] fifo_data;
  wire fifo_valid;
  wire pop;

  // Second and third stages must agree before a pin change counts
  function agreed;
    input [2:0] pipe;
    input prev;
    begin
      agreed = (pipe[1] == pipe[2]) ? pipe[2] : prev;
    end
  endfunction

  wire sync_now = agreed(sync_pipe, sync_q);
  wire sclk_now = agreed(sclk_pipe, sclk_q);
  wire sclk_fall = sclk_q && !sclk_now;
  wire sync_fall = sync_q && !sync_now;
  wire sync_rise = !sync_q && sync_now;
  wire last_bit = (bit_cnt == WORD_BITS[CW-1:0] - {{(CW-1){1'b0}}, 1'b1});
  // A rise in the same cycle as an edge wins: the bit is not taken
  wire take_bit = (state == ST_SHIFT) && !sync_rise && sclk_fall;

  always @*
  begin
    next_state = state;
    case (state)
      ST_IDLE:
        if (sync_fall)
          next_state = ST_SHIFT;
      ST_SHIFT:
        if (sync_rise)
          next_state = ST_IDLE;
        else if (sclk_fall && last_bit)
          next_state = ST_DONE;
      ST_DONE:
        if (sync_rise)
          next_state = ST_IDLE;
      default:
        next_state = ST_IDLE;
    endcase
  end

  // Pin stage: three flops per pin, nothing reads the first one
  always @(posedge clk_sys_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      // Select idles high; a zero here would fake a frame start
      sync_pipe <= 3'h7;
      sclk_pipe <= 3'h0;
      din_pipe <= 3'h0;
      sync_q <= 1'b1;
      sclk_q <= 1'b0;
    end
    else
    begin
      sync_pipe <= {sync_pipe[1:0], sync_n_in};
      sclk_pipe <= {sclk_pipe[1:0], sclk_in};
      din_pipe <= {din_pipe[1:0], din_in};
      sync_q <= sync_now;
      sclk_q <= sclk_now;
    end
  end

  // Frame state, bit counter and shifter
  always @(posedge clk_sys_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      state <= ST_IDLE;
      shreg <= {WORD_BITS{1'b0}};
      bit_cnt <= {CW{1'b0}};
      push <= 1'b0;
      push_data <= {WORD_BITS{1'b0}};
      active_out <= 1'b0;
    end
    else
    begin
      state <= next_state;
      push <= 1'b0;
      active_out <= (next_state == ST_SHIFT);
      if (state == ST_IDLE && sync_fall)
        bit_cnt <= {CW{1'b0}};
      if (take_bit)
      begin
        shreg <= {shreg[WORD_BITS-2:0], din_pipe[2]};
        bit_cnt <= bit_cnt + {{(CW-1){1'b0}}, 1'b1};
        if (last_bit)
        begin
          push <= 1'b1;
          push_data <= {shreg[WORD_BITS-2:0], din_pipe[2]};
        end
      end
    end
  end

  // One-cycle status pulses
  always @(posedge clk_sys_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      update_out <= 1'b0;
      abort_out <= 1'b0;
      overflow_out <= 1'b0;
    end
    else
    begin
      update_out <= take_bit && last_bit;
      abort_out <= (state == ST_SHIFT) && sync_rise;
      // No room: the new word is lost, flagged for one cycle
      overflow_out <= push && !fifo_ready;
    end
  end

  // Output register stage; stalls the FIFO drain on word_ready_in
  assign pop = fifo_valid && (!word_valid_out || word_ready_in);

  always @(posedge clk_sys_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      word_out <= {WORD_BITS{1'b0}};
      word_valid_out <= 1'b0;
    end
    else if (pop)
    begin
      word_out <= fifo_data;
      word_valid_out <= 1'b1;
    end
    else if (word_ready_in)
      word_valid_out <= 1'b0;
  end

  sdw_fifo #(
    .WIDTH(WORD_BITS),
    .DEPTH(FIFO_DEPTH),
    .AW(AW)
  ) u_fifo (
    .clk_sys_in(clk_sys_in),
    .rst_n_in(rst_n_in),
    .wr_data_in(push_data),
    .wr_valid_in(push),
    .wr_ready_out(fifo_ready),
    .rd_data_out(fifo_data),
    .rd_valid_out(fifo_valid),
    .rd_ready_in(pop)
  );

endmodule // sdw_frontend

// ==== verif/sdw_frontend_monitor.sv ====
/* Port checker for sdw_frontend.
   Assumes the bind below and pins quiet in reset. */
`timescale 1ns/1ps
module sdw_frontend_mon #(
  parameter WORD_BITS = 24
) (
  input clk_sys_in,
  input rst_n_in,
  input sync_n_in,
  input word_ready_in,
  input active_out,
  input [WORD_BITS-1:0] word_out,
  input word_valid_out,
  input update_out,
  input abort_out,
  input overflow_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);
  a_pulse_excl: assert property (!(update_out && abort_out))
    else $error("update with abort");
  a_update_ends: assert property (update_out |-> !active_out && $past(active_out))
    else $error("update outside frame");
  a_abort_ends: assert property (abort_out |-> !active_out && $past(active_out))
    else $error("abort outside frame");
  a_frame_start: assert property ($fell(sync_n_in) ##1 !sync_n_in [*6] |-> active_out)
    else $error("frame not started");
  a_idle_high: assert property (sync_n_in [*8] |-> !active_out)
    else $error("active with select high");
  a_no_abort_low: assert property (!sync_n_in [*8] |-> !abort_out)
    else $error("abort with select low");
  a_word_holds: assert property (word_valid_out && !word_ready_in |=>
    word_valid_out && $stable(word_out))
    else $error("word lost");
  a_update_gap: assert property (update_out |=> !update_out [*8])
    else $error("updates too close");
  c_upd: cover property (update_out);
  c_abt: cover property (abort_out);
  c_ovf: cover property (overflow_out);
endmodule // sdw_frontend_mon
bind sdw_frontend sdw_frontend_mon #(.WORD_BITS(WORD_BITS)) mon_u (.clk_sys_in(clk_sys_in),
  .rst_n_in(rst_n_in), .sync_n_in(sync_n_in), .word_ready_in(word_ready_in),
  .active_out(active_out), .word_out(word_out), .word_valid_out(word_valid_out),
  .update_out(update_out), .abort_out(abort_out), .overflow_out(overflow_out));

// ==== verif/sdw_frontend_tb.sv ====
/* Bench for sdw_frontend with the host model.
   Assumes the bound checker. */
`timescale 1ns/1ps
module sdw_frontend_tb;
  logic clk_sys_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic word_ready_in = 1'b0;
  logic [23:0] last = 24'h0;
  wire sync_n, sclk, din, active, valid, upd, abt, ovf;
  wire [23:0] word;
  int miscompares = 0, compares = 0, cyc = 0, n_upd = 0, n_abt = 0, n_ovf = 0, n_acc = 0;
  initial forever #5 clk_sys_in = ~clk_sys_in;
  sdw_host hm_u (.clk_in(clk_sys_in), .sync_n_out(sync_n), .sclk_out(sclk), .din_out(din));
  sdw_frontend dut_u (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .sync_n_in(sync_n),
    .sclk_in(sclk), .din_in(din), .active_out(active), .word_out(word),
    .word_valid_out(valid), .word_ready_in(word_ready_in), .update_out(upd),
    .abort_out(abt), .overflow_out(ovf));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  always @(posedge clk_sys_in)
  begin
    cyc <= cyc + 1;
    n_upd <= n_upd + upd;
    n_abt <= n_abt + abt;
    n_ovf <= n_ovf + ovf;
    if (valid && word_ready_in)
    begin
      n_acc <= n_acc + 1;
      last <= word;
    end
    if (cyc == 20000)
    begin
      miscompares++;
      end_of_test();
    end
  end
  task automatic t_word(input logic [23:0] w, input int n);
    hm_u.send(w, n);
    chk(last, w);
    chk(active, 1'b0);
  endtask
  task automatic t_abort;
    hm_u.send(24'h3b1e07, 23);
    chk(n_abt, 1);
    chk(n_acc, 2);
  endtask
  task automatic t_fill;
    word_ready_in <= 1'b0;
    for (int i = 0; i < 34; i++)
      hm_u.send(24'ha50000 | i, 24);
    chk(n_ovf, 1);
    word_ready_in <= 1'b1;
    hm_u.wt(40);
    chk(n_acc, 35);
    chk(last, 24'ha50020);
  endtask
  initial
  begin
    repeat (20) @(posedge clk_sys_in);
    rst_n_in <= 1'b1;
    word_ready_in <= 1'b1;
    hm_u.wt(8);
    t_word(24'h9c36a5, 24);
    t_word(24'h5a63c9, 26);
    chk(n_upd, 2);
    t_abort();
    t_fill();
    end_of_test();
  end
endmodule // sdw_frontend_tb

// ==== verif/sdw_host_model.sv ====
/* Serial host model: select, clock and data pins.
   Assumes the bench clock; the serial clock stands still between frames. */
`timescale 1ns/1ps
module sdw_host (
  input clk_in,
  output logic sync_n_out = 1'b1,
  output logic sclk_out = 1'b1,
  output logic din_out = 1'b0
);
  task automatic wt(input int n);
    repeat (n) @(posedge clk_in);
  endtask
  task automatic send(input logic [23:0] w, input int n);
    sync_n_out <= 1'b0;
    wt(4);
    for (int i = 0; i < n; i++)
    begin
      din_out <= w[23 - (i % 24)];
      wt(4);
      sclk_out <= 1'b0;
      wt(4);
      sclk_out <= 1'b1;
    end
    wt(4);
    // Released data line must not look valid
    din_out <= ~din_out;
    sync_n_out <= 1'b1;
    wt(8);
  endtask
endmodule // sdw_host
